// ==== common/dl_event_pkg.sv ====
// constants for the data link event status and enable block
package dl_event_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] STATUS_OFFSET = 8'h06;
	localparam logic [7:0] ENABLE_OFFSET = 8'h07;

	// ------------------------------------------------------------
	// status and enable bit positions
	// ------------------------------------------------------------
	localparam int KIND_POS       = 7;
	localparam int TX_BEGUN_POS   = 6;
	localparam int RX_BEGUN_POS   = 5;
	localparam int TX_DONE_POS    = 4;
	localparam int RX_DONE_POS    = 3;
	localparam int CHECKSUM_POS   = 2;
	localparam int ABORT_POS      = 1;
	localparam int IDLE_POS       = 0;
	localparam int EVENT_COUNT    = 7;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [6:0] EVENT_RESET  = 7'h00;
	localparam logic [6:0] ENABLE_RESET = 7'h00;
	localparam logic [7:0] RDATA_RESET  = 8'h00;

	// message kind encodings
	localparam logic BIT_ORIENTED_KIND     = 1'b0;
	localparam logic MESSAGE_ORIENTED_KIND = 1'b1;

	// bus answer phase
	typedef enum logic [1:0] {
		PHASE_IDLE = 2'b01,
		PHASE_READ = 2'b10
	} phase_type;

endpackage : dl_event_pkg

// ==== hdl/event_latch.sv ====
// one sticky event bit that clears on a status read
`timescale 1ns/1ps

module event_latch (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic event_pulse,
	input  wire logic clear,
	output logic      flag
);
	import dl_event_pkg::*;

	typedef struct packed {
		logic flag_r;
	} latch_state_type;

	latch_state_type st_r;
	latch_state_type st_nxt;

	// set wins over clear so an event in the read cycle is kept
	always_comb begin
		st_nxt = st_r;
		if (event_pulse) begin
			st_nxt.flag_r = 1'b1;
		end else if (clear) begin
			st_nxt.flag_r = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag_r;

endmodule : event_latch

// ==== hdl/data_link_event_status.sv ====
// data link event status, enables and interrupt request
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps

// Operation
// - Bit 7 of status shows the last received message kind, read only.
// - Event bits 6..0 latch on their event and clear after a status read.
// - Bit 6 sets when the transmitter begins sending a message.
// - Bit 5 sets when the receiver begins receiving a message.
// - Bit 4 sets when the transmitter finishes sending a message.
// - Bit 3 sets on a complete received message or a full buffer.
// - Bit 2 sets when the received checksum is found in error.
// - Bit 1 sets when an abort of seven ones is seen on receive.
// - Bit 0 sets when the flag octet 0x7e is seen on receive.
// - Enable bits 6..3 gate the begin and done event interrupts.
// - All enables and status bits are zero after reset.
// - Enable bits 2..0 gate the checksum, abort and idle interrupts.
module data_link_event_status (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_strobe,
	input  wire logic       rd_strobe,
	output logic      [7:0] rdata,
	input  wire logic       tx_message_begun,
	input  wire logic       rx_message_begun,
	input  wire logic       tx_message_done,
	input  wire logic       rx_message_done,
	input  wire logic       rx_buffer_full,
	input  wire logic       checksum_fault_event,
	input  wire logic       abort_seen_event,
	input  wire logic       idle_flag_event,
	input  wire logic       rx_kind_valid,
	input  wire logic       rx_kind_message,
	output logic            irq_request
);
	import dl_event_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [6:0] enable_r;
		logic       kind_r;
		logic [7:0] rdata_r;
		logic       irq_r;
		phase_type  phase_r;
	} top_state_type;

	top_state_type st_r;
	top_state_type st_nxt;

	logic [6:0] event_set;
	logic [6:0] event_flags;
	logic       status_read;
	logic [7:0] status_view;

	// ------------------------------------------------------------
	// event mapping
	// ------------------------------------------------------------
	// transmit begin event
	assign event_set[TX_BEGUN_POS] = tx_message_begun;
	assign event_set[RX_BEGUN_POS] = rx_message_begun;
	assign event_set[TX_DONE_POS]  = tx_message_done;
	assign event_set[RX_DONE_POS]  = rx_message_done | rx_buffer_full;
	assign event_set[CHECKSUM_POS] = checksum_fault_event;
	assign event_set[ABORT_POS]    = abort_seen_event;
	assign event_set[IDLE_POS]     = idle_flag_event;

	// a read of the status register clears every event bit that has no new event in the same cycle
	assign status_read = rd_strobe && (addr == STATUS_OFFSET);

	genvar gi;
	generate
		for (gi = 0; gi < EVENT_COUNT; gi++) begin : g_latch
			event_latch u_latch (
				.clk         (clk),
				.rstn        (rstn),
				.event_pulse (event_set[gi]),
				.clear       (status_read),
				.flag        (event_flags[gi])
			);
		end
	endgenerate

	assign status_view = {st_r.kind_r, event_flags};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (rx_kind_valid) begin
			st_nxt.kind_r = rx_kind_message ? MESSAGE_ORIENTED_KIND
			                                : BIT_ORIENTED_KIND;
		end
		// enable register; bit 7 reserved and ignored
		if (wr_strobe && (addr == ENABLE_OFFSET)) begin
			st_nxt.enable_r = wdata[6:0];
		end
		// read data valid one cycle after the strobe only
		st_nxt.rdata_r = RDATA_RESET;
		st_nxt.phase_r = PHASE_IDLE;
		if (rd_strobe) begin
			st_nxt.phase_r = PHASE_READ;
			unique case (addr)
				STATUS_OFFSET: st_nxt.rdata_r = status_view;
				ENABLE_OFFSET: st_nxt.rdata_r = {1'b0, st_r.enable_r};
				default:       st_nxt.rdata_r = RDATA_RESET;
			endcase
		end
		// request level; uses next flags so it drops with the clear
		st_nxt.irq_r = |((event_set | (event_flags & {7{~status_read}}))
		                 & st_nxt.enable_r);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r.enable_r <= ENABLE_RESET;
			st_r.kind_r   <= BIT_ORIENTED_KIND;
			st_r.rdata_r  <= RDATA_RESET;
			st_r.irq_r    <= 1'b0;
			st_r.phase_r  <= PHASE_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata       = st_r.rdata_r;
	assign irq_request = st_r.irq_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence seq_read_status;
		rd_strobe && addr == STATUS_OFFSET;
	endsequence

	sequence seq_no_events;
		event_set == 7'h00;
	endsequence

	AST_CLEAR_ON_READ:
	assert property (@(posedge clk) disable iff (!rstn)
		seq_read_status ##0 seq_no_events |=> event_flags == 7'h00)
	else $error("event bits not cleared by status read");

	AST_SET_WINS:
	assert property (@(posedge clk) disable iff (!rstn)
		seq_read_status ##0 idle_flag_event |=> event_flags[IDLE_POS])
	else $error("event lost in read cycle");

	AST_TX_BEGIN:
	assert property (@(posedge clk) disable iff (!rstn)
		tx_message_begun |=> event_flags[TX_BEGUN_POS])
	else $error("transmit begin not latched");

	AST_RX_DONE_FULL:
	assert property (@(posedge clk) disable iff (!rstn)
		rx_buffer_full |=> event_flags[RX_DONE_POS])
	else $error("buffer full did not set receive done");

	AST_STICKY:
	assert property (@(posedge clk) disable iff (!rstn)
		event_flags[TX_DONE_POS] && !status_read |=>
		event_flags[TX_DONE_POS])
	else $error("transmit done dropped without read");

	AST_READ_VALUE:
	assert property (@(posedge clk) disable iff (!rstn)
		seq_read_status |=> rdata == $past(status_view))
	else $error("status read data wrong");

	AST_KIND:
	assert property (@(posedge clk) disable iff (!rstn)
		rx_kind_valid |=> st_r.kind_r == $past(rx_kind_message))
	else $error("message kind not updated");

	// uses the enable as written this cycle, so a same-cycle write counts
	AST_IRQ_GATE:
	assert property (@(posedge clk) disable iff (!rstn)
		|(event_flags & st_nxt.enable_r) && !status_read |=> irq_request)
	else $error("request missing for enabled event");

	AST_IRQ_MASKED:
	assert property (@(posedge clk) disable iff (!rstn)
		st_nxt.enable_r == 7'h00 |=> !irq_request)
	else $error("request raised with all enables off");

	AST_RDATA_ONE_CYCLE:
	assert property (@(posedge clk) disable iff (!rstn)
		!rd_strobe |=> rdata == 8'h00)
	else $error("read data outside answer cycle");

	// ------------------------------------------------------------
	// per event latching
	// ------------------------------------------------------------
	AST_RX_BEGIN:
	assert property (@(posedge clk) disable iff (!rstn)
		rx_message_begun |=> event_flags[RX_BEGUN_POS])
	else $error("receive begin not latched");

	AST_TX_DONE:
	assert property (@(posedge clk) disable iff (!rstn)
		tx_message_done |=> event_flags[TX_DONE_POS])
	else $error("transmit done not latched");

	AST_RX_DONE:
	assert property (@(posedge clk) disable iff (!rstn)
		rx_message_done |=> event_flags[RX_DONE_POS])
	else $error("receive done not latched");

	AST_CHECKSUM:
	assert property (@(posedge clk) disable iff (!rstn)
		checksum_fault_event |=> event_flags[CHECKSUM_POS])
	else $error("checksum fault not latched");

	AST_ABORT:
	assert property (@(posedge clk) disable iff (!rstn)
		abort_seen_event |=> event_flags[ABORT_POS])
	else $error("abort sequence not latched");

	AST_IDLE:
	assert property (@(posedge clk) disable iff (!rstn)
		idle_flag_event |=> event_flags[IDLE_POS])
	else $error("idle flag not latched");

	// ------------------------------------------------------------
	// kind, enables, request, read phase and reset
	// ------------------------------------------------------------
	AST_KIND_HOLD:
	assert property (@(posedge clk) disable iff (!rstn)
		!rx_kind_valid |=> st_r.kind_r == $past(st_r.kind_r))
	else $error("message kind changed without a message");

	AST_ENABLE_WRITE:
	assert property (@(posedge clk) disable iff (!rstn)
		wr_strobe && addr == ENABLE_OFFSET |=>
		{1'b0, st_r.enable_r} == ($past(wdata) & 8'h7f))
	else $error("enable write not taken");

	// strobes never overlap, so a status read cannot hide an enable write
	AST_IRQ_DROP:
	assert property (@(posedge clk) disable iff (!rstn)
		seq_read_status ##0 seq_no_events |=> !irq_request)
	else $error("request stayed after clearing read");

	AST_CHECKSUM_GATE:
	assert property (@(posedge clk) disable iff (!rstn)
		event_flags[CHECKSUM_POS] && st_nxt.enable_r[CHECKSUM_POS]
		&& !status_read |=> irq_request)
	else $error("checksum interrupt not raised");

	AST_PHASE_IDLE:
	assert property (@(posedge clk) disable iff (!rstn)
		st_r.phase_r == PHASE_IDLE |-> rdata == 8'h00)
	else $error("read data outside read phase");

	// checked while reset is held, so no disable here
	AST_RESET_ZERO:
	assert property (@(posedge clk)
		!rstn |-> rdata == 8'h00 && !irq_request
		&& event_flags == 7'h00 && st_r.enable_r == 7'h00)
	else $error("state not zero in reset");

endmodule : data_link_event_status

// ==== tb/test_data_link_event_status.sv ====
// self-checking bench for the data link event status block
`timescale 1ns/1ps

module test_data_link_event_status;
	import dl_event_pkg::*;

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr_strobe = 1'b0;
	logic        rd_strobe = 1'b0;
	logic [7:0]  ev_in = 8'h00;
	logic        kind_valid = 1'b0;
	logic        kind_msg = 1'b0;
	logic [7:0]  rdata;
	logic        irq_request;
	logic [7:0]  rd;
	logic [31:0] seed = 32'h0000_0002;
	bit          rnd_on = 1'b0;
	int          mismatches = 0;
	int          checked = 0;
	logic [6:0]  status_model;
	logic [6:0]  enable_model;
	logic        kind_model;
	logic        irq_model;
	logic [7:0]  rdata_model;

	data_link_event_status dut (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.tx_message_begun(ev_in[7]), .rx_message_begun(ev_in[6]),
		.tx_message_done(ev_in[5]), .rx_message_done(ev_in[4]),
		.rx_buffer_full(ev_in[3]), .checksum_fault_event(ev_in[2]),
		.abort_seen_event(ev_in[1]), .idle_flag_event(ev_in[0]),
		.rx_kind_valid(kind_valid), .rx_kind_message(kind_msg),
		.irq_request(irq_request)
	);

	always #2 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs

	task automatic check(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report;
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// one bus cycle, result taken in the answer cycle
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		wr_strobe <= wr;
		rd_strobe <= !wr;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask : bus

	task automatic pulse(input logic [7:0] e);
		@(posedge clk);
		ev_in <= e;
		@(posedge clk);
		ev_in <= 8'h00;
	endtask : pulse

	// ------------------------------------------------------------
	// reference model, updated on the same edges as the design
	// ------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_model = EVENT_RESET;
			enable_model = ENABLE_RESET;
			kind_model = BIT_ORIENTED_KIND;
			irq_model = 1'b0;
			rdata_model = RDATA_RESET;
		end else begin
			rdata_model = 8'h00;
			if (rd_strobe && addr == STATUS_OFFSET) begin
				rdata_model = {kind_model, status_model};
				status_model = 7'h00;
			end else if (rd_strobe && addr == ENABLE_OFFSET)
				rdata_model = {1'b0, enable_model};
			// a new event wins over the clearing read
			status_model = status_model | {ev_in[7:5], ev_in[4] | ev_in[3],
				ev_in[2:0]};
			if (wr_strobe && addr == ENABLE_OFFSET)
				enable_model = wdata[6:0];
			if (kind_valid)
				kind_model = kind_msg;
			irq_model = |(status_model & enable_model);
		end
	end

	// compare every settled cycle out of reset
	always @(negedge clk) begin
		if (rstn) begin
			check("kind flag", {7'h00, rdata[7]}, {7'h00, rdata_model[7]});
			check("status", {1'b0, rdata[6:0]}, {1'b0, rdata_model[6:0]});
			check("irq", {7'h00, irq_request}, {7'h00, irq_model});
		end
	end

	// random traffic; sparse events so reads see a mix of bits
	always @(posedge clk) begin
		if (rnd_on) begin
			seed = xs(seed);
			ev_in <= seed[7:0] & seed[15:8] & seed[23:16];
			kind_valid <= seed[24];
			kind_msg <= seed[25];
			rd_strobe <= seed[27:26] == 2'b01;
			wr_strobe <= seed[27:26] == 2'b10;
			addr <= seed[28] ? {7'h03, seed[29]} : {seed[31:29], seed[20:16]};
			wdata <= seed[31:24];
		end
	end

	task automatic random_run;
		@(negedge clk);
		rnd_on = 1'b1;
		repeat (3000) @(posedge clk);
		@(negedge clk);
		rnd_on = 1'b0;
		@(posedge clk);
		{ev_in, kind_valid, rd_strobe, wr_strobe} <= 11'h000;
	endtask : random_run

	initial begin
		#80000;
		mismatches++;
		final_report();
	end

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, STATUS_OFFSET, 8'h00, rd);
		check("status after reset", rd, RDATA_RESET);
		bus(1'b0, ENABLE_OFFSET, 8'h00, rd);
		check("enable after reset", rd, RDATA_RESET);
		bus(1'b1, ENABLE_OFFSET, 8'hff, rd);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			bus(1'b0, STATUS_OFFSET, 8'h00, rd);
			check("event bit", rd, 8'h01 << (i < 4 ? i : i - 1));
		end
		@(posedge clk);
		kind_valid <= 1'b1;
		kind_msg <= 1'b1;
		@(posedge clk);
		kind_valid <= 1'b0;
		bus(1'b1, STATUS_OFFSET, 8'h00, rd);
		bus(1'b0, STATUS_OFFSET, 8'h00, rd);
		check("kind read only", rd, {MESSAGE_ORIENTED_KIND, 7'h00});
		// idle flag together with receive done marks a whole message
		pulse(8'h11);
		bus(1'b0, STATUS_OFFSET, 8'h00, rd);
		check("whole message", rd, {MESSAGE_ORIENTED_KIND, 7'h09});
		// enable register write between transmit begin and transmit done
		pulse(8'h80);
		bus(1'b1, ENABLE_OFFSET, 8'h7f, rd);
		pulse(8'h20);
		bus(1'b0, STATUS_OFFSET, 8'h00, rd);
		check("refill window", rd, {MESSAGE_ORIENTED_KIND, 7'h50});
		random_run();
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		random_run();
		final_report();
	end

endmodule : test_data_link_event_status
